/* File: core/seq_dep_pkg.sv */
// constants for the output dependency logic of outputs four and five
package seq_dep_pkg;

   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned EE_ADDR_W = 16;
   localparam int unsigned NUM_REGS = 16;
   localparam int unsigned IDX_W = 4;
   localparam int unsigned TERM_W = 25;

   // eeprom copy of register n sits at this base plus its register address REG_ADDR[n], not plus n
   localparam logic [EE_ADDR_W-1:0] EE_BASE = 16'h8000;

   // register indices into the table below
   localparam int unsigned IDX_O4_P1_A = 0;
   localparam int unsigned IDX_O4_P1_B = 1;
   localparam int unsigned IDX_O4_P1_C = 2;
   localparam int unsigned IDX_O4_P2_A = 3;
   localparam int unsigned IDX_O4_P2_B = 4;
   localparam int unsigned IDX_O4_P2_C = 5;
   localparam int unsigned IDX_O4_O8 = 6;
   localparam int unsigned IDX_O5_P1_A = 7;
   localparam int unsigned IDX_O5_P1_B = 8;
   localparam int unsigned IDX_O5_P1_C = 9;
   localparam int unsigned IDX_O5_P2_A = 10;
   localparam int unsigned IDX_O5_P2_B = 11;
   localparam int unsigned IDX_O5_P2_C = 12;
   localparam int unsigned IDX_O5_P1_O8 = 13;
   localparam int unsigned IDX_O5_P2_O8 = 14;
   localparam int unsigned IDX_MR = 15;

   localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REGS] = '{
      8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23,
      8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h3b, 8'h40};

   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

   // single-bit fields in shared registers
   localparam int unsigned O4_P1_OUT8_BIT = 0;
   localparam int unsigned O4_P2_OUT8_BIT = 1;
   localparam int unsigned O5_P1_OUT8_BIT = 0;
   localparam int unsigned O5_P2_OUT8_BIT = 4;
   localparam int unsigned MR_OUT4_BIT = 3;
   localparam int unsigned MR_OUT5_BIT = 4;

   // selections that exist only on the larger variant are cleared here
   localparam logic [TERM_W-1:0] FULL_VARIANT_MASK = 25'h1ffffff;
   localparam logic [TERM_W-1:0] SMALL_VARIANT_MASK = 25'h0f3cfcf;

   typedef enum logic [1:0] {
      LOAD_ISSUE,
      LOAD_WAIT,
      RUNNING
   } load_state_t;

endpackage

/* File: core/cfg_byte_reg.sv */
// one configuration byte: eeprom load or software write
module cfg_byte_reg #(
   parameter int unsigned WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic load_i,
   input wire logic [WIDTH-1:0] load_data_i,
   input wire logic write_i,
   input wire logic [WIDTH-1:0] write_data_i,
   output logic [WIDTH-1:0] value_o
);

   // load and write never coincide: writes are only taken once loading ends
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         value_o <= RESET_VALUE;
      end else if (load_i) begin
         value_o <= load_data_i;
      end else if (write_i) begin
         value_o <= write_data_i;
      end
   end

endmodule // cfg_byte_reg

/* File: core/product_term.sv */
// one product term: true when at least one condition is selected and all selected conditions are healthy
module product_term #(
   parameter int unsigned WIDTH = 25
) (
   input wire logic [WIDTH-1:0] select_i,
   input wire logic [WIDTH-1:0] fault_i,
   input wire logic [WIDTH-1:0] variant_mask_i,
   output logic term_o
);

   logic [WIDTH-1:0] eff_select;

   // bits absent on the small variant are ignored even if set
   assign eff_select = select_i & variant_mask_i;

   // an empty term is false, so a blank configuration keeps the output asserted
   assign term_o = (|eff_select) & ~(|(eff_select & fault_i));

endmodule // product_term

/* File: core/output_dependency_logic.sv */
// dependency logic of programmable outputs four and five
// Behaviour
// R01: pri-threshold select bits 0-3 of 0x24 tie output five to inputs one-four.
// R02: 0x24 bits 4-5 select inputs five-six; ignored on the small variant.
// R03: 0x24 bits 6-7 tie output five to watchdog one and two.
// R04: 0x25 bits 0-3 select secondary threshold of inputs one-four.
// R05: 0x25 bits 4-5 select secondary of inputs five-six, large variant only.
// R06: 0x25 bits 6-7 select logic inputs one and two.
// R07: 0x26 bits 0-1 select logic inputs three and four.
// R08: 0x26 bits 2-3 select outputs one and two, large variant only.
// R09: 0x26 bits 4-7 select the other outputs three, four, six, seven.
// R10: 0x2a bit 0 selects output eight, large variant only.
// R11: 0x40 bit 4 set: low manual reset asserts output five.
// R12: a cleared select bit removes that condition entirely.
// R13: output five deasserts when either of its product terms is true.
// R14: output four likewise deasserts when either of its terms is true.
// R15: second term of output five uses same layout at 0x27-0x29.
// R16: a term is true only if all selected conditions are healthy.
// R17: selections load from eeprom after reset, then software may overwrite.
module output_dependency_logic #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [5:0] primary_fault_i,
   input wire logic [5:0] secondary_fault_i,
   input wire logic [1:0] watchdog_fault_i,
   input wire logic [3:0] logic_input_fault_i,
   input wire logic [5:0] ext_output_asserted_i,
   input wire logic manual_reset_n_i,
   input wire logic [seq_dep_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [seq_dep_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [seq_dep_pkg::DATA_W-1:0] reg_rdata_o,
   output logic eeprom_rd_o,
   output logic [seq_dep_pkg::EE_ADDR_W-1:0] eeprom_addr_o,
   input wire logic eeprom_valid_i,
   input wire logic [seq_dep_pkg::DATA_W-1:0] eeprom_data_i,
   output logic config_ready_o,
   output logic prog_output_four_o,
   output logic prog_output_five_o
);

   localparam logic [seq_dep_pkg::IDX_W-1:0] LAST_IDX = seq_dep_pkg::IDX_W'(seq_dep_pkg::NUM_REGS - 1);
   localparam logic [seq_dep_pkg::TERM_W-1:0] VARIANT_MASK =
      LARGE_VARIANT ? seq_dep_pkg::FULL_VARIANT_MASK : seq_dep_pkg::SMALL_VARIANT_MASK;

   seq_dep_pkg::load_state_t state;
   logic [seq_dep_pkg::IDX_W-1:0] load_idx;
   logic [seq_dep_pkg::DATA_W-1:0] cfg [seq_dep_pkg::NUM_REGS];
   logic [seq_dep_pkg::NUM_REGS-1:0] addr_hit;
   logic load_last;

   logic [seq_dep_pkg::TERM_W-1:0] sel4_p1;
   logic [seq_dep_pkg::TERM_W-1:0] sel4_p2;
   logic [seq_dep_pkg::TERM_W-1:0] sel5_p1;
   logic [seq_dep_pkg::TERM_W-1:0] sel5_p2;
   logic [seq_dep_pkg::TERM_W-1:0] fault4;
   logic [seq_dep_pkg::TERM_W-1:0] fault5;
   logic term4_p1;
   logic term4_p2;
   logic term5_p1;
   logic term5_p2;
   logic mr_force4;
   logic mr_force5;
   logic next_out4;
   logic next_out5;

   assign load_last = (load_idx == LAST_IDX);

   // eeprom load walks every register once, one read at a time
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state <= seq_dep_pkg::LOAD_ISSUE;
         load_idx <= '0;
      end else begin
         case (state)
            seq_dep_pkg::LOAD_ISSUE: begin
               state <= seq_dep_pkg::LOAD_WAIT;
            end
            seq_dep_pkg::LOAD_WAIT: begin
               if (eeprom_valid_i) begin
                  if (load_last) begin
                     state <= seq_dep_pkg::RUNNING; // [R17]
                  end else begin
                     state <= seq_dep_pkg::LOAD_ISSUE;
                     load_idx <= load_idx + 1'b1;
                  end
               end
            end
            seq_dep_pkg::RUNNING: begin
               state <= seq_dep_pkg::RUNNING;
            end
            default: begin
               state <= seq_dep_pkg::LOAD_ISSUE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         eeprom_rd_o <= 1'b0;
         eeprom_addr_o <= seq_dep_pkg::EE_BASE;
      end else begin
         eeprom_rd_o <= (state == seq_dep_pkg::LOAD_ISSUE);
         eeprom_addr_o <= seq_dep_pkg::EE_BASE | {8'h00, seq_dep_pkg::REG_ADDR[load_idx]};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         config_ready_o <= 1'b0;
      end else begin
         config_ready_o <= (state == seq_dep_pkg::RUNNING)
            || (state == seq_dep_pkg::LOAD_WAIT && eeprom_valid_i && load_last);
      end
   end

   // software writes are refused until the eeprom image is in place
   for (genvar i = 0; i < seq_dep_pkg::NUM_REGS; i++) begin : g_cfg
      assign addr_hit[i] = (reg_addr_i == seq_dep_pkg::REG_ADDR[i]);
      cfg_byte_reg #(
         .WIDTH(seq_dep_pkg::DATA_W),
         .RESET_VALUE(seq_dep_pkg::REG_RESET)
      ) u_reg (
         .ref_clk_i(ref_clk_i),
         .srst_i(srst_i),
         .load_i(state == seq_dep_pkg::LOAD_WAIT && eeprom_valid_i && load_idx == i), // [R17]
         .load_data_i(eeprom_data_i),
         .write_i(state == seq_dep_pkg::RUNNING && reg_wr_i && addr_hit[i]), // [R17]
         .write_data_i(reg_wdata_i),
         .value_o(cfg[i])
      );
   end

   // unmapped reads return zero
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= '0;
         for (int i = 0; i < seq_dep_pkg::NUM_REGS; i++) begin
            if (addr_hit[i]) begin
               reg_rdata_o <= cfg[i];
            end
         end
      end
   end

   // selection layout: pri[5:0] wdog[1:0] sec[5:0] gpi[3:0] outs[5:0] out8
   assign sel5_p1 = {cfg[seq_dep_pkg::IDX_O5_P1_O8][seq_dep_pkg::O5_P1_OUT8_BIT], // [R10]
                     cfg[seq_dep_pkg::IDX_O5_P1_C], // [R07] [R08] [R09]
                     cfg[seq_dep_pkg::IDX_O5_P1_B], // [R04] [R05] [R06]
                     cfg[seq_dep_pkg::IDX_O5_P1_A]}; // [R01] [R02] [R03]
   assign sel5_p2 = {cfg[seq_dep_pkg::IDX_O5_P2_O8][seq_dep_pkg::O5_P2_OUT8_BIT],
                     cfg[seq_dep_pkg::IDX_O5_P2_C],
                     cfg[seq_dep_pkg::IDX_O5_P2_B],
                     cfg[seq_dep_pkg::IDX_O5_P2_A]}; // [R15]
   assign sel4_p1 = {cfg[seq_dep_pkg::IDX_O4_O8][seq_dep_pkg::O4_P1_OUT8_BIT],
                     cfg[seq_dep_pkg::IDX_O4_P1_C],
                     cfg[seq_dep_pkg::IDX_O4_P1_B],
                     cfg[seq_dep_pkg::IDX_O4_P1_A]};
   assign sel4_p2 = {cfg[seq_dep_pkg::IDX_O4_O8][seq_dep_pkg::O4_P2_OUT8_BIT],
                     cfg[seq_dep_pkg::IDX_O4_P2_C],
                     cfg[seq_dep_pkg::IDX_O4_P2_B],
                     cfg[seq_dep_pkg::IDX_O4_P2_A]};

   // ext outputs: {eight, seven, six, three, two, one}; four and five are ours, registered to avoid a loop
   assign fault5 = {ext_output_asserted_i[5], ext_output_asserted_i[4], ext_output_asserted_i[3],
                    prog_output_four_o, ext_output_asserted_i[2:0],
                    logic_input_fault_i, secondary_fault_i, watchdog_fault_i, primary_fault_i}; // [R09]
   assign fault4 = {ext_output_asserted_i[5], ext_output_asserted_i[4], ext_output_asserted_i[3],
                    prog_output_five_o, ext_output_asserted_i[2:0],
                    logic_input_fault_i, secondary_fault_i, watchdog_fault_i, primary_fault_i};

   product_term #(.WIDTH(seq_dep_pkg::TERM_W)) u_t5_p1 (
      .select_i(sel5_p1),
      .fault_i(fault5),
      .variant_mask_i(VARIANT_MASK), // [R02] [R05] [R08] [R10]
      .term_o(term5_p1) // [R12] [R16]
   );
   product_term #(.WIDTH(seq_dep_pkg::TERM_W)) u_t5_p2 (
      .select_i(sel5_p2),
      .fault_i(fault5),
      .variant_mask_i(VARIANT_MASK),
      .term_o(term5_p2)
   );
   product_term #(.WIDTH(seq_dep_pkg::TERM_W)) u_t4_p1 (
      .select_i(sel4_p1),
      .fault_i(fault4),
      .variant_mask_i(VARIANT_MASK),
      .term_o(term4_p1)
   );
   product_term #(.WIDTH(seq_dep_pkg::TERM_W)) u_t4_p2 (
      .select_i(sel4_p2),
      .fault_i(fault4),
      .variant_mask_i(VARIANT_MASK),
      .term_o(term4_p2)
   );

   assign mr_force5 = cfg[seq_dep_pkg::IDX_MR][seq_dep_pkg::MR_OUT5_BIT] & ~manual_reset_n_i; // [R11]
   assign mr_force4 = cfg[seq_dep_pkg::IDX_MR][seq_dep_pkg::MR_OUT4_BIT] & ~manual_reset_n_i;

   // manual reset overrides a true term; outputs held asserted while loading
   assign next_out5 = mr_force5 | ~(term5_p1 | term5_p2); // [R13] [R16]
   assign next_out4 = mr_force4 | ~(term4_p1 | term4_p2); // [R14]

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         prog_output_five_o <= 1'b1;
      end else if (state == seq_dep_pkg::RUNNING) begin
         prog_output_five_o <= next_out5;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         prog_output_four_o <= 1'b1;
      end else if (state == seq_dep_pkg::RUNNING) begin
         prog_output_four_o <= next_out4;
      end
   end

   primary_dep_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R01]
      sel5_p1[0] && primary_fault_i[0] |-> !term5_p1) else $error("primary fault did not block term");

   small_variant_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R02]
      sel5_p1 == 25'h0000020 |-> term5_p1 == (LARGE_VARIANT && !primary_fault_i[5]))
      else $error("input six selection wrong for variant");

   watchdog_dep_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R03]
      sel5_p1[6] && watchdog_fault_i[0] |-> !term5_p1) else $error("watchdog fault did not block term");

   secondary_dep_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R04]
      sel5_p1[8] && secondary_fault_i[0] |-> !term5_p1) else $error("secondary fault did not block term");

   upper_secondary_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R05]
      sel5_p1 == 25'h0002000 |-> term5_p1 == (LARGE_VARIANT && !secondary_fault_i[5]))
      else $error("input six secondary selection wrong for variant");

   gpi_dep_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R06]
      sel5_p1[14] && logic_input_fault_i[0] |-> !term5_p1) else $error("logic input fault ignored");

   gpi_three_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R07]
      sel5_p1[16] && logic_input_fault_i[2] |-> !term5_p1) else $error("logic input three fault ignored");

   output_one_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R08]
      sel5_p1 == 25'h0040000 |-> term5_p1 == (LARGE_VARIANT && !ext_output_asserted_i[0]))
      else $error("output one selection wrong for variant");

   output_four_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R09]
      sel5_p1[21] && prog_output_four_o |-> !term5_p1) else $error("asserted output four ignored");

   output_eight_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R10]
      sel5_p1 == 25'h1000000 |-> term5_p1 == (LARGE_VARIANT && !ext_output_asserted_i[5]))
      else $error("output eight selection wrong for variant");

   mr_force_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R11]
      state == seq_dep_pkg::RUNNING && mr_force5 |=> prog_output_five_o) else $error("manual reset not obeyed");

   mr_four_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R14]
      state == seq_dep_pkg::RUNNING && mr_force4 |=> prog_output_four_o)
      else $error("manual reset not obeyed by output four");

   single_select_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R12]
      sel5_p1 == 25'h0000001 |-> term5_p1 == !primary_fault_i[0])
      else $error("unselected condition took effect");

   empty_term_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R12]
      (sel5_p1 & VARIANT_MASK) == '0 |-> !term5_p1) else $error("empty term evaluated true");

   out5_deassert_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R13]
      state == seq_dep_pkg::RUNNING && term5_p1 && !mr_force5 |=> !prog_output_five_o)
      else $error("output five stayed asserted");

   out4_deassert_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R14]
      state == seq_dep_pkg::RUNNING && (term4_p1 || term4_p2) && !mr_force4 |=> !prog_output_four_o)
      else $error("output four stayed asserted");

   out4_held_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R14]
      state == seq_dep_pkg::RUNNING && !term4_p1 && !term4_p2 |=> prog_output_four_o)
      else $error("output four released with no term");

   second_term_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R15]
      state == seq_dep_pkg::RUNNING && term5_p2 && !mr_force5 |=> !prog_output_five_o)
      else $error("second term ignored");

   second_dep_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R15]
      sel5_p2[0] && primary_fault_i[0] |-> !term5_p2) else $error("second term ignored a fault");

   held_asserted_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R16]
      state == seq_dep_pkg::RUNNING && !term5_p1 && !term5_p2 |=> prog_output_five_o)
      else $error("output five released with no term");

   load_done_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R17]
      state == seq_dep_pkg::LOAD_WAIT && eeprom_valid_i && load_last |=> config_ready_o && !$past(config_ready_o))
      else $error("ready not raised after last load");

   load_held_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R17]
      state != seq_dep_pkg::RUNNING |=> prog_output_five_o && prog_output_four_o)
      else $error("output released while loading");

   sw_write_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R17]
      state == seq_dep_pkg::RUNNING && reg_wr_i && reg_addr_i == 8'h24
      |=> cfg[seq_dep_pkg::IDX_O5_P1_A] == $past(reg_wdata_i))
      else $error("software write lost");

endmodule // output_dependency_logic

/* File: dv/test_output_dependency_logic.sv */
// self-checking testbench with a lockstep model of outputs four and five
module test_output_dependency_logic;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i, srst_i, manual_reset_n_i, reg_wr_i, reg_rd_i, eeprom_valid_i, chk, rdy_s, m4, m5;
   logic [5:0] primary_fault_i, secondary_fault_i, ext_output_asserted_i;
   logic [1:0] watchdog_fault_i;
   logic [3:0] logic_input_fault_i;
   logic [7:0] reg_addr_i, reg_wdata_i, eeprom_data_i, reg_rdata_o, mrd;
   logic [15:0] eeprom_addr_o;
   logic eeprom_rd_o, config_ready_o, prog_output_four_o, prog_output_five_o;
   logic [7:0] mreg [16];
   logic [24:0] sel;
   int midx, n_fail, compares;
   integer seed;

   output_dependency_logic #(.LARGE_VARIANT(1'b1)) i_dut (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .primary_fault_i(primary_fault_i),
      .secondary_fault_i(secondary_fault_i), .watchdog_fault_i(watchdog_fault_i),
      .logic_input_fault_i(logic_input_fault_i), .ext_output_asserted_i(ext_output_asserted_i),
      .manual_reset_n_i(manual_reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .eeprom_rd_o(eeprom_rd_o), .eeprom_addr_o(eeprom_addr_o), .eeprom_valid_i(eeprom_valid_i),
      .eeprom_data_i(eeprom_data_i), .config_ready_o(config_ready_o),
      .prog_output_four_o(prog_output_four_o), .prog_output_five_o(prog_output_five_o));

   // condition vector in select-bit order; other is the neighbour output
   function automatic logic [24:0] fvec(input logic other);
      return {ext_output_asserted_i[5:3], other, ext_output_asserted_i[2:0], logic_input_fault_i,
              secondary_fault_i, watchdog_fault_i, primary_fault_i};
   endfunction

   // an empty selection never fires, so an unconfigured output stays asserted
   function automatic logic term(input logic [24:0] s, input logic [24:0] f);
      return (s != 25'h0) && ((s & f) == 25'h0);
   endfunction

   function automatic logic [7:0] rdm(input logic [7:0] a);
      rdm = 8'h00;
      for (int i = 0; i < 16; i++) if (a == seq_dep_pkg::REG_ADDR[i]) rdm = mreg[i];
   endfunction

   always @(posedge ref_clk_i) begin : model
      logic n4, n5;
      rdy_s = (midx == 16);
      n4 = !(term({mreg[6][0], mreg[2], mreg[1], mreg[0]}, fvec(m5))
             | term({mreg[6][1], mreg[5], mreg[4], mreg[3]}, fvec(m5)));
      n5 = !(term({mreg[13][0], mreg[9], mreg[8], mreg[7]}, fvec(m4))
             | term({mreg[14][4], mreg[12], mreg[11], mreg[10]}, fvec(m4)));
      if (mreg[15][3] && !manual_reset_n_i) n4 = 1'b1;
      if (mreg[15][4] && !manual_reset_n_i) n5 = 1'b1;
      if (reg_rd_i) mrd = rdm(reg_addr_i);
      if (srst_i) begin
         for (int i = 0; i < 16; i++) mreg[i] = 8'h00;
         m4 = 1'b1;
         m5 = 1'b1;
         midx = 0;
         mrd = 8'h00;
      end else begin
         if (eeprom_valid_i && midx < 16) begin
            mreg[midx] = eeprom_data_i;
            midx++;
         end
         if (reg_wr_i && rdy_s) for (int i = 0; i < 16; i++)
            if (reg_addr_i == seq_dep_pkg::REG_ADDR[i]) mreg[i] = reg_wdata_i;
         m4 = rdy_s ? n4 : 1'b1;
         m5 = rdy_s ? n5 : 1'b1;
      end
   end

   // results compared mid-cycle, clear of the launching edge
   always @(negedge ref_clk_i) begin
      if (chk) begin
         check(16'(config_ready_o), 16'(midx == 16));
         check(16'(prog_output_five_o), 16'(m5));
         check(16'(prog_output_four_o), 16'(m4));
         check(16'(reg_rdata_o), 16'(mrd));
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      reg_wr_i = w;
      reg_rd_i = r;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge ref_clk_i);
      #1;
   endtask

   task automatic faults(input logic [24:0] v);
      primary_fault_i = v[5:0];
      secondary_fault_i = v[11:6];
      watchdog_fault_i = v[13:12];
      logic_input_fault_i = v[17:14];
      ext_output_asserted_i = v[23:18];
      manual_reset_n_i = v[24];
   endtask

   task automatic reset_load();
      int k;
      srst_i = 1'b1;
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      chk = 1'b1;
      repeat (14) bus(1'b0, 1'b0, 8'h00, 8'h00);
      check(eeprom_addr_o, seq_dep_pkg::EE_BASE);
      srst_i = 1'b0;
      for (int i = 0; i < 16; i++) begin
         k = 0;
         while (eeprom_rd_o !== 1'b1 && k < 10) begin
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            k++;
         end
         check(16'(k), 16'h0001);
         check(16'(eeprom_rd_o), 16'h0001);
         check(eeprom_addr_o, seq_dep_pkg::EE_BASE + 16'(seq_dep_pkg::REG_ADDR[i]));
         check(16'(config_ready_o), 16'h0000);
         eeprom_valid_i = 1'b1;
         eeprom_data_i = 8'($random(seed) & $random(seed));
         // a write while loading must be dropped
         bus(i == 3, 1'b0, 8'h1d, 8'hff);
         eeprom_valid_i = 1'b0;
      end
      k = 0;
      while (config_ready_o !== 1'b1 && k < 5) begin
         bus(1'b0, 1'b0, 8'h00, 8'h00);
         k++;
      end
      check(16'(config_ready_o), 16'h0001);
   endtask

   task automatic rand_run(input int n);
      logic [31:0] r;
      logic [7:0] a;
      for (int j = 0; j < n; j++) begin
         r = $random(seed);
         faults({r[7:0] != 8'h00, 24'($random(seed) & $random(seed))});
         a = r[8] ? seq_dep_pkg::REG_ADDR[r[12:9]] : r[20:13];
         case (r[22:21])
            2'd0: bus(1'b1, 1'b0, a, 8'($random(seed) & $random(seed) & $random(seed)));
            2'd1: bus(1'b0, 1'b1, a, 8'h00);
            default: bus(1'b0, 1'b0, 8'h00, 8'h00);
         endcase
      end
   endtask

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      seed = 32'hecd9;
      chk = 1'b0;
      srst_i = 1'b1;
      eeprom_valid_i = 1'b0;
      eeprom_data_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      faults(25'h1000000);
      @(posedge ref_clk_i);
      #1;
      reset_load();
      // loaded image read back; the early write to the first byte must be absent
      for (int i = 0; i < 16; i++) bus(1'b0, 1'b1, seq_dep_pkg::REG_ADDR[i], 8'h00);
      for (int i = 0; i < 16; i++) bus(1'b1, 1'b0, seq_dep_pkg::REG_ADDR[i], 8'h00);
      // one select bit at a time, healthy then faulty
      for (int b = 0; b < 25; b++) begin
         sel = 25'h1 << b;
         bus(1'b1, 1'b0, 8'h24, sel[7:0]);
         bus(1'b1, 1'b0, 8'h25, sel[15:8]);
         bus(1'b1, 1'b0, 8'h26, sel[23:16]);
         bus(1'b1, 1'b0, 8'h2a, {7'h00, sel[24]});
         bus(1'b0, 1'b1, 8'h26, 8'h00);
         faults(25'h1000000);
         repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
         faults(25'h1ffffff);
         repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
      end
      bus(1'b1, 1'b0, 8'h24, 8'h01);
      bus(1'b1, 1'b0, 8'h40, 8'h18);
      faults(25'h1000000);
      repeat (3) bus(1'b0, 1'b1, 8'h40, 8'h00);
      faults(25'h0000000);
      repeat (3) bus(1'b0, 1'b1, 8'h00, 8'h00);
      rand_run(1500);
      reset_load();
      rand_run(500);
      report_and_stop();
   end
endmodule // test_output_dependency_logic
